// *** shared/adc_cfg_pkg.sv ***
// Behaviour
// - channels 2-9 decode codes 001..111 to 6.5..640.5 cycles; 000 reserved.
// - channels 0 and 1 decode code 000 as 2.5 cycles, others alike.
// - sample-time register packs 3-bit fields, channel 0 lowest, channel 9 at 29:27.
// - each preempted result is raw data, or the oversampled value while preempted oversampling is enabled, minus that slot's 12-bit offset.
// - 16-bit upper monitor boundary, read/write, resets to all ones.
// - 16-bit lower monitor boundary, read/write, resets to zero.
// - ordinary length code n runs n+1 conversions, one to sixteen.
// - each ordinary slot holds a 5-bit channel; slot 1 at bits 4:0.
// - preempted length code n runs n+1 conversions, one to four.
// - preempted scan starts at slot four minus length code, ends at slot 4.
// - four read-only 16-bit preempted results, reset to zero.
// - read-only 16-bit ordinary result holds latest data, resets to zero.
// - resume select 0 keeps ordinary accumulation after preemption; 1 restarts it.
// - per-sample trigger 0 needs one trigger; 1 needs a trigger for each ordinary oversampled sample.
// - shift field right-shifts the oversampled result by 0 to 8 bits.
// - ratio code n accumulates 2 to the power n+1 samples.
// - preempted conversions are oversampled only while their enable is set.
// - ordinary conversions are oversampled only while their enable is set.
// - without scan enable only one channel is converted per trigger.
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SAMPLE_TIME = 8'h00;
  localparam logic [7:0] OFS_PRE_OFFSET_1 = 8'h04;
  localparam logic [7:0] OFS_UPPER = 8'h14;
  localparam logic [7:0] OFS_LOWER = 8'h18;
  localparam logic [7:0] OFS_ORD_SEQ_A = 8'h1C;
  localparam logic [7:0] OFS_ORD_SEQ_B = 8'h20;
  localparam logic [7:0] OFS_ORD_SEQ_C = 8'h24;
  localparam logic [7:0] OFS_PRE_SEQ = 8'h28;
  localparam logic [7:0] OFS_PRE_RESULT_1 = 8'h2C;
  localparam logic [7:0] OFS_ORD_RESULT = 8'h3C;
  localparam logic [7:0] OFS_OVS_CTRL = 8'h40;
  localparam logic [7:0] OFS_SCAN_CTRL = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;

  // writable bits of each register
  localparam logic [31:0] MASK_SAMPLE_TIME = 32'h3FFF_FFFF;
  localparam logic [31:0] MASK_PRE_OFFSET = 32'h0000_0FFF;
  localparam logic [31:0] MASK_BOUND = 32'h0000_FFFF;
  localparam logic [31:0] MASK_ORD_SEQ_A = 32'h00FF_FFFF;
  localparam logic [31:0] MASK_ORD_SEQ_BC = 32'h3FFF_FFFF;
  localparam logic [31:0] MASK_PRE_SEQ = 32'h003F_FFFF;
  localparam logic [31:0] MASK_OVS_CTRL = 32'h0000_07FF;
  localparam logic [31:0] MASK_SCAN_CTRL = 32'h0000_0001;

  localparam logic [15:0] RESET_UPPER = 16'hFFFF;
  localparam logic [15:0] RESET_LOWER = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SPT_W = 3;
  localparam int SLOT_W = 5;
  localparam int ORD_LEN_LSB = 20;
  localparam int PRE_LEN_LSB = 20;
  localparam int OVS_ORD_EN = 0;
  localparam int OVS_PRE_EN = 1;
  localparam int OVS_RATIO_LSB = 2;
  localparam int OVS_SHIFT_LSB = 5;
  localparam int OVS_PER_TRIG = 9;
  localparam int OVS_RESUME = 10;
  localparam int SCAN_EN_BIT = 0;
  localparam int SPT_CHANNELS = 10;
  localparam logic [4:0] FAST_CHANNELS = 5'h02;

  // ----------------------------------------------------------------
  // sample times in half converter clock cycles
  // ----------------------------------------------------------------
  localparam logic [10:0] HALF_2P5 = 11'h005;
  localparam logic [10:0] HALF_6P5 = 11'h00D;
  localparam logic [10:0] HALF_12P5 = 11'h019;
  localparam logic [10:0] HALF_24P5 = 11'h031;
  localparam logic [10:0] HALF_47P5 = 11'h05F;
  localparam logic [10:0] HALF_92P5 = 11'h0B9;
  localparam logic [10:0] HALF_247P5 = 11'h1EF;
  localparam logic [10:0] HALF_640P5 = 11'h501;

  localparam int ACC_W = 20;
  localparam int CNT_W = 8;
  localparam logic [1:0] PRE_LAST_SLOT = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_START, ST_WAIT} seq_state_type;

  typedef struct packed {
    logic start;
    logic [4:0] channel;
    logic [10:0] sample_half;
  } conv_req_type;

  typedef struct packed {
    logic done;
    logic [11:0] data;
  } conv_rsp_type;

endpackage : adc_cfg_pkg

// *** src/adc_accumulator.sv ***
`timescale 1ns/1ps
module adc_accumulator
  import adc_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic add,
  input wire logic [2:0] ratio_code,
  input wire logic [3:0] shift_code,
  // sample and result
  input wire logic [11:0] sample,
  output logic last,
  output logic [15:0] result
);
  logic [ACC_W-1:0] acc_q;
  logic [CNT_W-1:0] count_q;
  logic [ACC_W-1:0] sum;
  logic [8:0] target_m1;

  // ----------------------------------------------------------------
  // running sum including the present sample
  // ----------------------------------------------------------------
  assign target_m1 = (9'h002 << ratio_code) - 9'h001;
  assign last = ({1'b0, count_q} == target_m1);
  assign sum = acc_q + {{(ACC_W-12){1'b0}}, sample};
  assign result = 16'(sum >> shift_code);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      count_q <= '0;
    end else if (clear || (add && last)) begin
      acc_q <= '0;
      count_q <= '0;
    end else if (add) begin
      acc_q <= sum;
      count_q <= count_q + 8'h01;
    end
  end

endmodule : adc_accumulator

// *** src/adc_seq_config.sv ***
`timescale 1ns/1ps
module adc_seq_config
  import adc_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // triggers
  input wire logic ordinary_trigger,
  input wire logic preempted_trigger,
  // converter core
  output adc_cfg_pkg::conv_req_type conv_req,
  input wire adc_cfg_pkg::conv_rsp_type conv_rsp,
  // monitor boundaries
  output logic [15:0] monitor_upper_value,
  output logic [15:0] monitor_lower_value
);
  import adc_cfg_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] sample_half(input logic [2:0] code, input logic [4:0] ch);
    logic [10:0] half;
    half = HALF_6P5;
    case (code)
      3'h0: half = (ch < FAST_CHANNELS) ? HALF_2P5 : HALF_6P5;
      3'h1: half = HALF_6P5;
      3'h2: half = HALF_12P5;
      3'h3: half = HALF_24P5;
      3'h4: half = HALF_47P5;
      3'h5: half = HALF_92P5;
      3'h6: half = HALF_247P5;
      3'h7: half = HALF_640P5;
      default: half = HALF_6P5;
    endcase
    return half;
  endfunction : sample_half

  function automatic logic [4:0] word_index(input logic [ADDR_W-1:0] addr);
    return 5'(addr[ADDR_W-1:2]);
  endfunction : word_index

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= OFS_STATUS);
  endfunction : mapped

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [29:0] sample_time_q;
  logic [11:0] pre_offset_q [4];
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [23:0] ord_seq_a_q;
  logic [29:0] ord_seq_b_q;
  logic [29:0] ord_seq_c_q;
  logic [21:0] pre_seq_q;
  logic [15:0] pre_result_q [4];
  logic [15:0] ord_result_q;
  logic [10:0] ovs_q;
  logic scan_en_q;
  logic [31:0] prdata_q;

  logic wr_en;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  seq_state_type state_q;
  logic group_pre_q;
  logic [3:0] ord_slot_q;
  logic [1:0] pre_slot_q;
  logic ord_active_q;
  logic pre_pend_q;
  logic [4:0] channel_q;
  logic [10:0] sample_q;

  logic [3:0] ord_len;
  logic [1:0] pre_len;
  logic [4:0] ord_channel;
  logic [4:0] pre_channel;
  logic [4:0] next_channel;
  logic [2:0] next_code;
  logic ord_os_en;
  logic pre_os_en;
  logic per_trig;
  logic pre_taken;
  logic ord_resume;
  logic ord_new;
  logic done;
  logic ord_add;
  logic pre_add;
  logic ord_last;
  logic pre_last;
  logic [15:0] ord_acc_result;
  logic [15:0] pre_acc_result;
  logic ord_sample_done;
  logic pre_sample_done;
  logic ord_seq_end;
  logic pre_seq_end;
  logic ord_clear;
  logic pre_clear;
  logic [15:0] pre_value;

  // ----------------------------------------------------------------
  // apb slave: zero wait, read data captured in the setup cycle
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata = prdata_q;
  assign wr_en = psel && penable && pwrite && mapped(paddr);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (word_index(paddr))
      5'h00: rd_word = {2'h0, sample_time_q};
      5'h01, 5'h02, 5'h03, 5'h04: rd_word = {20'h00000, pre_offset_q[2'(word_index(paddr) - 5'h01)]};
      5'h05: rd_word = {16'h0000, upper_q};
      5'h06: rd_word = {16'h0000, lower_q};
      5'h07: rd_word = {8'h00, ord_seq_a_q};
      5'h08: rd_word = {2'h0, ord_seq_b_q};
      5'h09: rd_word = {2'h0, ord_seq_c_q};
      5'h0A: rd_word = {10'h000, pre_seq_q};
      5'h0B, 5'h0C, 5'h0D, 5'h0E: rd_word = {16'h0000, pre_result_q[2'(word_index(paddr) - 5'h0B)]};
      5'h0F: rd_word = {16'h0000, ord_result_q};
      5'h10: rd_word = {21'h000000, ovs_q};
      5'h11: rd_word = {31'h00000000, scan_en_q};
      5'h12: rd_word = {26'h0000000, pre_pend_q, ord_active_q, group_pre_q, ord_slot_q == 4'h0,
        state_q != ST_IDLE, 1'b0};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= mapped(paddr) ? rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // writable configuration
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_time_q <= '0;
      upper_q <= RESET_UPPER;
      lower_q <= RESET_LOWER;
      ord_seq_a_q <= '0;
      ord_seq_b_q <= '0;
      ord_seq_c_q <= '0;
      pre_seq_q <= '0;
      ovs_q <= '0;
      scan_en_q <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        OFS_SAMPLE_TIME: sample_time_q <= 30'(pwdata & MASK_SAMPLE_TIME);
        OFS_UPPER: upper_q <= 16'(pwdata & MASK_BOUND);
        OFS_LOWER: lower_q <= 16'(pwdata & MASK_BOUND);
        OFS_ORD_SEQ_A: ord_seq_a_q <= 24'(pwdata & MASK_ORD_SEQ_A);
        OFS_ORD_SEQ_B: ord_seq_b_q <= 30'(pwdata & MASK_ORD_SEQ_BC);
        OFS_ORD_SEQ_C: ord_seq_c_q <= 30'(pwdata & MASK_ORD_SEQ_BC);
        OFS_PRE_SEQ: pre_seq_q <= 22'(pwdata & MASK_PRE_SEQ);
        OFS_OVS_CTRL: ovs_q <= 11'(pwdata & MASK_OVS_CTRL);
        OFS_SCAN_CTRL: scan_en_q <= pwdata[SCAN_EN_BIT];
        default: ;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_offset
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pre_offset_q[gi] <= '0;
        end else if (wr_en && paddr == OFS_PRE_OFFSET_1 + 8'(4 * gi)) begin
          pre_offset_q[gi] <= 12'(pwdata & MASK_PRE_OFFSET);
        end
      end
    end
  endgenerate

  assign monitor_upper_value = upper_q;
  assign monitor_lower_value = lower_q;

  // ----------------------------------------------------------------
  // slot decode
  // ----------------------------------------------------------------
  assign ord_len = ord_seq_a_q[ORD_LEN_LSB +: 4];
  assign pre_len = pre_seq_q[PRE_LEN_LSB +: 2];
  assign ord_os_en = ovs_q[OVS_ORD_EN];
  assign pre_os_en = ovs_q[OVS_PRE_EN];
  assign per_trig = ovs_q[OVS_PER_TRIG];

  always_comb begin
    ord_channel = 5'h00;
    if (ord_slot_q < 4'h6) begin
      ord_channel = ord_seq_c_q[SLOT_W * int'(ord_slot_q) +: SLOT_W];
    end else if (ord_slot_q < 4'hC) begin
      ord_channel = ord_seq_b_q[SLOT_W * (int'(ord_slot_q) - 6) +: SLOT_W];
    end else begin
      ord_channel = ord_seq_a_q[SLOT_W * (int'(ord_slot_q) - 12) +: SLOT_W];
    end
  end

  assign pre_channel = pre_seq_q[SLOT_W * int'(pre_slot_q) +: SLOT_W];
  assign next_channel = group_pre_q ? pre_channel : ord_channel;
  assign next_code = (next_channel < 5'(SPT_CHANNELS)) ?
    sample_time_q[SPT_W * int'(next_channel) +: SPT_W] : 3'h0;

  // ----------------------------------------------------------------
  // sequencing control terms
  // ----------------------------------------------------------------
  assign done = (state_q == ST_WAIT) && conv_rsp.done;
  assign pre_taken = (state_q == ST_IDLE) && (pre_pend_q || preempted_trigger);
  assign ord_resume = (state_q == ST_IDLE) && !pre_taken && ord_active_q &&
    (!(per_trig && ord_os_en) || ordinary_trigger);
  assign ord_new = (state_q == ST_IDLE) && !pre_taken && !ord_active_q && ordinary_trigger;
  assign ord_add = done && !group_pre_q && ord_os_en;
  assign pre_add = done && group_pre_q && pre_os_en;
  assign ord_sample_done = done && !group_pre_q && (!ord_os_en || ord_last);
  assign pre_sample_done = done && group_pre_q && (!pre_os_en || pre_last);
  assign ord_seq_end = !scan_en_q || (ord_slot_q == ord_len);
  assign pre_seq_end = !scan_en_q || (pre_slot_q == PRE_LAST_SLOT);
  assign ord_clear = ord_new ||
    (pre_sample_done && pre_seq_end && ord_active_q && ovs_q[OVS_RESUME]);
  assign pre_clear = pre_taken;

  adc_accumulator u_ord_acc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(ord_clear),
    .add(ord_add),
    .ratio_code(ovs_q[OVS_RATIO_LSB +: 3]),
    .shift_code(ovs_q[OVS_SHIFT_LSB +: 4]),
    .sample(conv_rsp.data),
    .last(ord_last),
    .result(ord_acc_result)
  );

  adc_accumulator u_pre_acc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(pre_clear),
    .add(pre_add),
    .ratio_code(ovs_q[OVS_RATIO_LSB +: 3]),
    .shift_code(ovs_q[OVS_SHIFT_LSB +: 4]),
    .sample(conv_rsp.data),
    .last(pre_last),
    .result(pre_acc_result)
  );

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (pre_taken || ord_resume || ord_new) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: state_q <= ST_START;
        ST_START: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (!conv_rsp.done) begin
            state_q <= ST_WAIT;
          end else if (group_pre_q) begin
            state_q <= (pre_sample_done && pre_seq_end) ? ST_IDLE : ST_LOAD;
          end else if (pre_pend_q || preempted_trigger) begin
            state_q <= ST_IDLE;
          end else if (ord_sample_done && ord_seq_end) begin
            state_q <= ST_IDLE;
          end else if (per_trig && ord_os_en) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_LOAD;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // group select and pending preempted request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_pre_q <= 1'b0;
      pre_pend_q <= 1'b0;
    end else begin
      if (pre_taken) begin
        group_pre_q <= 1'b1;
      end else if (ord_resume || ord_new) begin
        group_pre_q <= 1'b0;
      end
      pre_pend_q <= (preempted_trigger && state_q != ST_IDLE) || (pre_pend_q && !pre_taken);
    end
  end

  // slot pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ord_slot_q <= 4'h0;
      pre_slot_q <= 2'h0;
      ord_active_q <= 1'b0;
    end else begin
      if (pre_taken) begin
        pre_slot_q <= PRE_LAST_SLOT - pre_len;
      end else if (pre_sample_done && !pre_seq_end) begin
        pre_slot_q <= pre_slot_q + 2'h1;
      end
      if (ord_new) begin
        ord_slot_q <= 4'h0;
        ord_active_q <= 1'b1;
      end else if (ord_sample_done) begin
        ord_slot_q <= ord_seq_end ? 4'h0 : ord_slot_q + 4'h1;
        ord_active_q <= !ord_seq_end;
      end
    end
  end

  // converter request, loaded one cycle before the start strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_q <= 5'h00;
      sample_q <= HALF_2P5;
    end else if (state_q == ST_LOAD) begin
      channel_q <= next_channel;
      sample_q <= sample_half(next_code, next_channel);
    end
  end

  assign conv_req.start = (state_q == ST_START);
  assign conv_req.channel = channel_q;
  assign conv_req.sample_half = sample_q;

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  assign pre_value = pre_os_en ? pre_acc_result : {4'h0, conv_rsp.data};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ord_result_q <= 16'h0000;
    end else if (ord_sample_done) begin
      ord_result_q <= ord_os_en ? ord_acc_result : {4'h0, conv_rsp.data};
    end
  end

  generate
    for (gi = 0; gi < 4; gi++) begin : g_pre_result
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pre_result_q[gi] <= 16'h0000;
        end else if (pre_sample_done && pre_slot_q == 2'(gi)) begin
          pre_result_q[gi] <= pre_value - {4'h0, pre_offset_q[gi]};
        end
      end
    end
  endgenerate

endmodule : adc_seq_config

// *** test/adc_seq_config_sva.sv ***
`timescale 1ns/1ps
module adc_seq_config_sva
  import adc_cfg_pkg::*;
(
  // bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // converter side
  input wire adc_cfg_pkg::conv_req_type conv_req,
  input wire logic [15:0] monitor_upper_value,
  input wire logic [15:0] monitor_lower_value
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // sample time shadow
  // ----
  localparam logic [10:0] HT [8] = '{HALF_2P5, HALF_6P5, HALF_12P5, HALF_24P5,
    HALF_47P5, HALF_92P5, HALF_247P5, HALF_640P5};
  logic wr;
  logic [15:0] wlo;
  logic [31:0] spt_q;
  assign wr = psel && penable && pwrite;
  assign wlo = pwdata[15:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spt_q <= 32'h0;
    end else if (wr && paddr == OFS_SAMPLE_TIME) begin
      spt_q <= pwdata & MASK_SAMPLE_TIME;
    end
  end
  function automatic logic [10:0] half_of(input logic [4:0] ch);
    logic [2:0] c;
    c = (ch < 5'h0A) ? spt_q[ch*3 +: 3] : 3'h0;
    half_of = (c == 3'h0 && ch >= FAST_CHANNELS) ? HALF_6P5 : HT[c];
  endfunction : half_of
  a_upper_write:
    assert property (wr && paddr == OFS_UPPER |=> monitor_upper_value == $past(wlo))
    else $error("upper bound not written");
  a_lower_write:
    assert property (wr && paddr == OFS_LOWER |=> monitor_lower_value == $past(wlo))
    else $error("lower bound not written");
  a_bound_reset:
    assert property ($rose(presetn) |-> monitor_upper_value == RESET_UPPER
      && monitor_lower_value == RESET_LOWER)
    else $error("bound reset value wrong");
  a_bounds_hold:
    assert property (!wr |=> $stable(monitor_upper_value) && $stable(monitor_lower_value))
    else $error("bound changed without write");
  a_read_upper:
    assert property (psel && !penable && !pwrite && paddr == OFS_UPPER
      |=> prdata == {16'h0000, $past(monitor_upper_value)})
    else $error("upper bound read wrong");
  a_read_lower:
    assert property (psel && !penable && !pwrite && paddr == OFS_LOWER
      |=> prdata == {16'h0000, $past(monitor_lower_value)})
    else $error("lower bound read wrong");
  a_sample_time:
    assert property (conv_req.start |-> conv_req.sample_half == half_of(conv_req.channel))
    else $error("sample time decode wrong");
  a_start_pulse:
    assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
endmodule : adc_seq_config_sva

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import adc_cfg_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ordinary_trigger = 1'b0;
  logic preempted_trigger = 1'b0;
  conv_req_type conv_req;
  conv_rsp_type conv_rsp = '0;
  logic [15:0] upper;
  logic [15:0] lower;
  int err_total = 0;
  int comparisons = 0;
  logic [10:0] ht[8] = '{HALF_2P5, HALF_6P5, HALF_12P5, HALF_24P5, HALF_47P5,
    HALF_92P5, HALF_247P5, HALF_640P5};
  logic [4:0] chs[3] = '{5'h00, 5'h02, 5'h09};
  int rt[3] = '{0, 1, 7};
  int sh[3] = '{0, 2, 8};
  logic [31:0] r, spt, s1, s2, s3;
  logic e;
  int sum;
  always #5 pclk = ~pclk;
  adc_seq_config adc_seq_config_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ordinary_trigger(ordinary_trigger),
    .preempted_trigger(preempted_trigger), .conv_req(conv_req), .conv_rsp(conv_rsp),
    .monitor_upper_value(upper), .monitor_lower_value(lower));
  // ----
  // tasks
  // ----
  task automatic finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("[ERR] wait expected answer seen timeout");
      finish_test();
    end
  endtask : tmo
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    tmo(n, 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask : rd
  function automatic logic [10:0] hf(input logic [4:0] ch);
    logic [2:0] c;
    c = (ch < 5'h0A) ? spt[ch*3 +: 3] : 3'h0;
    hf = (c == 3'h0 && ch >= 5'h02) ? HALF_6P5 : ht[c];
  endfunction : hf
  task automatic trig(input logic p);
    if (p) preempted_trigger <= 1'b1;
    else ordinary_trigger <= 1'b1;
    @(posedge pclk);
    if (p) preempted_trigger <= 1'b0;
    else ordinary_trigger <= 1'b0;
  endtask : trig
  // core answers one cycle after each start
  task automatic conv(input logic [4:0] ch, input logic [11:0] d);
    int n;
    n = 0;
    @(negedge pclk);
    while (conv_req.start !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    tmo(n, 200);
    chk("channel", 32'(ch), 32'(conv_req.channel));
    chk("sample time", 32'(hf(ch)), 32'(conv_req.sample_half));
    @(posedge pclk);
    conv_rsp <= {1'b1, d};
    @(posedge pclk);
    conv_rsp.done <= 1'b0;
  endtask : conv
  task automatic idle(input int c);
    int k;
    k = 0;
    repeat (c) begin
      @(negedge pclk);
      if (conv_req.start === 1'b1) k++;
    end
    @(posedge pclk);
    chk("extra starts", 32'h0, 32'(k));
  endtask : idle
  // ----
  // sequence
  // ----
  initial begin
    spt = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("upper bound", OFS_UPPER, 32'h0000_FFFF);
    rd("lower bound", OFS_LOWER, 32'h0);
    rd("ordinary result", OFS_ORD_RESULT, 32'h0);
    rd("preempted result", OFS_PRE_RESULT_1 + 8'h0C, 32'h0);
    rd("sequence", OFS_ORD_SEQ_A, 32'h0);
    rd("preempted sequence", OFS_PRE_SEQ, 32'h0);
    apb(1'b1, OFS_UPPER, 32'h0000_1234);
    apb(1'b1, OFS_LOWER, 32'h0000_ABCD);
    apb(1'b1, OFS_ORD_RESULT, 32'h0000_5555);
    rd("upper bound", OFS_UPPER, 32'h0000_1234);
    chk("upper pin", 32'h1234, 32'(upper));
    rd("lower bound", OFS_LOWER, 32'h0000_ABCD);
    rd("ordinary result", OFS_ORD_RESULT, 32'h0);
    apb(1'b0, 8'h4C, 32'h0);
    chk("error flag", 32'h1, 32'(e));
    for (int k = 0; k < 8; k++) begin
      spt = {2'h0, 3'(7 - k), 18'h0, 3'(k), 3'(k), 3'(k)};
      apb(1'b1, OFS_SAMPLE_TIME, spt);
      foreach (chs[j]) begin
        apb(1'b1, OFS_ORD_SEQ_C, 32'(chs[j]));
        trig(1'b0);
        conv(chs[j], 12'(12'h800 + k));
        rd("ordinary result", OFS_ORD_RESULT, 32'h800 + k);
      end
    end
    spt = 32'h0;
    s1 = 32'h00F0_0000;
    s2 = 32'h0;
    s3 = 32'h0;
    for (int i = 0; i < 6; i++) begin
      s3[i*5 +: 5] = 5'(i + 1);
      s2[i*5 +: 5] = 5'(i + 7);
      if (i < 4) s1[i*5 +: 5] = 5'(i + 13);
    end
    apb(1'b1, OFS_SAMPLE_TIME, spt);
    apb(1'b1, OFS_ORD_SEQ_A, s1);
    apb(1'b1, OFS_ORD_SEQ_B, s2);
    apb(1'b1, OFS_ORD_SEQ_C, s3);
    apb(1'b1, OFS_SCAN_CTRL, 32'h1);
    trig(1'b0);
    for (int i = 1; i <= 16; i++) conv(5'(i), 12'(i));
    idle(20);
    apb(1'b1, OFS_SCAN_CTRL, 32'h0);
    trig(1'b0);
    conv(5'h01, 12'h001);
    idle(20);
    apb(1'b1, OFS_SCAN_CTRL, 32'h1);
    for (int x = 0; x < 4; x++) apb(1'b1, OFS_PRE_OFFSET_1 + 8'(4 * x), 32'(160 * (x + 1)));
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, OFS_PRE_SEQ, {10'h0, 2'(l), 5'h06, 5'h05, 5'h04, 5'h03});
      trig(1'b1);
      for (int s = 3 - l; s < 4; s++) conv(5'(s + 3), 12'(12'h100 + s));
      idle(20);
    end
    for (int s = 0; s < 4; s++) begin
      rd("preempted result", OFS_PRE_RESULT_1 + 8'(4 * s),
        32'(16'(16'h0100 + s - 16'h00A0 * (s + 1))));
    end
    apb(1'b1, OFS_SCAN_CTRL, 32'h0);
    apb(1'b1, OFS_ORD_SEQ_C, 32'h2);
    for (int q = 0; q < 3; q++) begin
      apb(1'b1, OFS_OVS_CTRL, 32'h1 | 32'(rt[q]) << 2 | 32'(sh[q]) << 5);
      sum = 0;
      trig(1'b0);
      for (int i = 0; i < (2 << rt[q]); i++) begin
        conv(5'h02, 12'(12'hFFF - i));
        sum += 4095 - i;
      end
      idle(10);
      rd("accumulated", OFS_ORD_RESULT, 32'(16'(sum >> sh[q])));
    end
    apb(1'b1, OFS_OVS_CTRL, 32'h2);
    apb(1'b1, OFS_PRE_SEQ, 32'h0003_0000);
    trig(1'b1);
    conv(5'h06, 12'h200);
    conv(5'h06, 12'h200);
    idle(10);
    rd("preempted result", OFS_PRE_RESULT_1 + 8'h0C, 32'h0180);
    apb(1'b1, OFS_OVS_CTRL, 32'h0000_0201);
    trig(1'b0);
    conv(5'h02, 12'h010);
    idle(20);
    trig(1'b0);
    conv(5'h02, 12'h020);
    idle(5);
    rd("per trigger result", OFS_ORD_RESULT, 32'h30);
    // preempted scan cuts into ordinary oversampling in restart mode
    apb(1'b1, OFS_OVS_CTRL, 32'h0000_0401);
    trig(1'b0);
    trig(1'b1);
    conv(5'h02, 12'h100);
    conv(5'h06, 12'h050);
    conv(5'h02, 12'h010);
    conv(5'h02, 12'h020);
    idle(10);
    rd("restart result", OFS_ORD_RESULT, 32'h30);
    rd("preempted result", OFS_PRE_RESULT_1 + 8'h0C, 32'hFDD0);
    finish_test();
  end
endmodule : testbench
bind adc_seq_config adc_seq_config_sva adc_seq_config_sva_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .conv_req(conv_req), .monitor_upper_value(monitor_upper_value),
  .monitor_lower_value(monitor_lower_value));
